/* src/aeo_regs.svh */
// Register offsets, field positions, reset values and counts of the event and orientation bank.
`ifndef AEO_REGS_SVH
`define AEO_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses on the device register port)
// ==========================================================================
`define AEO_OFF_EVENT      4'h0
`define AEO_OFF_READY      4'h1
`define AEO_OFF_INSTANT    4'h2
`define AEO_OFF_XHI        4'h3
`define AEO_OFF_XLO        4'h4
`define AEO_OFF_YHI        4'h5

// ==========================================================================
// Field positions and masks
// ==========================================================================
`define AEO_EVENT_MASK     8'hCF
`define AEO_BIT_XY_CHG     3'h6
`define AEO_BIT_Z_CHG      3'h7
`define AEO_BIT_FRESH_ACK  3'h0
`define AEO_BIT_SOFT_RST   3'h4

// ==========================================================================
// Reset values and counts
// ==========================================================================
`define AEO_RST_BYTE       8'h00
`define AEO_RST_ORIENT     4'h0
`define AEO_XY_THRESH_LSB  12'h180
`define AEO_ORIENT_BASE    8'h10

`endif

/* src/aeo_pkg.sv */
// Types shared by the event and orientation register bank.
package aeo_pkg;

    // ======================================================================
    // Register port request and sensor sample carriers
    // ======================================================================
    typedef struct packed {
        logic        wr;     // One-cycle write strobe.
        logic        rd;     // One-cycle read strobe.
        logic [3:0]  addr;   // Register offset.
        logic [7:0]  wdata;  // Write data.
    } aeo_reg_req_t;

    typedef struct packed {
        logic        valid;  // One-cycle pulse: a new reading is complete.
        logic [11:0] x;      // Two's complement X acceleration.
        logic [11:0] y;      // Two's complement Y acceleration.
        logic [11:0] z;      // Two's complement Z acceleration.
    } aeo_sample_t;

    // Orientation: tilt flag, Z direction and XY plane code.
    typedef struct packed {
        logic        tilt;
        logic        z_neg;
        logic [1:0]  xy;
    } aeo_orient_t;

    // Soft restart sequencer, Gray coded along RUN, HOLD, RELEASE.
    typedef enum logic [1:0] {
        AEO_RUN     = 2'b00,
        AEO_HOLD    = 2'b01,
        AEO_RELEASE = 2'b11
    } aeo_rst_state_t;

    // Complete state of the bank.
    typedef struct packed {
        logic [7:0]     evt_flags;   // Shake and orientation change flags.
        logic [7:0]     evt_ack;     // Self-clearing clear register.
        logic           fresh;       // New sample flag.
        logic           fresh_ack;   // Self-clearing clear bit for it.
        aeo_orient_t    filt;        // Filtered orientation.
        aeo_orient_t    inst;        // Instantaneous orientation.
        aeo_orient_t    pend;        // Candidate orientation being counted.
        logic [7:0]     cnt;         // Consecutive candidate readings.
        logic           calib;       // Calibration loaded, sticky.
        logic [11:0]    x;           // Last X sample.
        logic [11:0]    y;           // Last Y sample.
        logic [2:0]     busy_sync;   // Transfer busy synchroniser.
        logic           busy;        // Filtered transfer busy level.
        aeo_rst_state_t rst_st;      // Soft restart sequencer.
        logic [7:0]     rdata;       // Read data.
        logic           int_act;     // Interrupt request.
    } aeo_state_t;

endpackage

/* src/aeo_event_orient_bank.sv */
// Event flag, orientation status and X output register bank of the motion sensor.
//
// Function
// - Six byte registers at offsets zero to five of sixteen.
// - Flag and clear registers share offsets zero, one.
// - Events set their flag regardless of enable.
// - Written one clears flag, clear bit self-clears.
// - Written zero leaves the flag untouched.
// - Bits zero to three: shake +X,-X,+Y,-Y.
// - Set shake flag blocks further detections on axis.
// - Bit six XY change, bit seven Z change.
// - Clear bits mirror flag positions; four, five unused.
// - Filtered XY code in bits five and four.
// - XY updates only above magnitude threshold.
// - Z field: tilt upper bit, direction lower bit.
// - Strong tilt reports vertical Z by sign.
// - Tilt holds the XY orientation field.
// - Commit orientation after consecutive identical readings.
// - Count code selects 16, 32, 64, 128 readings.
// - New sample sets ready bit; clear bit zero.
// - Soft restart bit resets all but interface and calibration bit.
// - Soft restart holds while transfer is busy.
// - Offset two shows unfiltered orientation.
// - Calibration loaded bit is sticky.
// - X sample split across offsets three, four.
// - Open-drain interrupt from enabled flag bits.
`timescale 1ns/1ps
`default_nettype none
`include "aeo_regs.svh"

module aeo_event_orient_bank (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire aeo_pkg::aeo_reg_req_t i_reg_req,
    output logic [7:0]                 o_reg_rdata,
    input  wire logic [7:0]            i_other_rdata,
    input  wire logic                  i_xfer_busy,
    input  wire aeo_pkg::aeo_sample_t  i_sample,
    input  wire logic [3:0]            i_shake_hit,
    input  wire logic                  i_calib_done,
    input  wire logic [1:0]            i_fsr,
    input  wire logic [1:0]            i_orient_count,
    input  wire logic [7:0]            i_event_enable,
    input  wire logic [2:0]            i_ready_enable,
    output logic [3:0]                 o_shake_armed,
    output logic                       o_soft_restart,
    output logic                       o_int_n_o,
    output logic                       o_int_n_oe
);

    // ======================================================================
    // State and working signals
    // ======================================================================
    aeo_pkg::aeo_state_t  st_reg;      // Registered state.
    aeo_pkg::aeo_state_t  st_next;     // Next state.
    logic                 wr_event;    // Write to offset zero.
    logic                 wr_ready;    // Write to offset one.
    logic [11:0]          mag_x;       // Magnitude of X.
    logic [11:0]          mag_y;       // Magnitude of Y.
    logic [11:0]          mag_big;     // Larger of the two.
    logic [11:0]          xy_thresh;   // Validity threshold at this range.
    logic                 tilt_now;    // Reading lacks XY amplitude.
    logic [1:0]           xy_now;      // XY code of this reading.
    aeo_pkg::aeo_orient_t inst_now;    // Unfiltered orientation.
    aeo_pkg::aeo_orient_t cand;        // Candidate for the filtered value.
    logic [7:0]           target;      // Readings needed to commit.
    logic [3:0]           armed;       // Shake detection enabled per axis.

    // ======================================================================
    // Combinational helpers
    // ======================================================================

    // Both strobes share the offsets of the flag registers.
    assign wr_event  = i_reg_req.wr && (i_reg_req.addr == `AEO_OFF_EVENT);
    assign wr_ready  = i_reg_req.wr && (i_reg_req.addr == `AEO_OFF_READY);
    // Magnitudes; the most negative value maps to 2048 without overflow.
    assign mag_x     = i_sample.x[11] ? 12'(~i_sample.x + 12'h001) : i_sample.x;
    assign mag_y     = i_sample.y[11] ? 12'(~i_sample.y + 12'h001) : i_sample.y;
    assign mag_big   = (mag_x >= mag_y) ? mag_x : mag_y;
    // The threshold is fixed in g, so it halves as the range doubles.
    assign xy_thresh = `AEO_XY_THRESH_LSB >> i_fsr;
    assign tilt_now  = !(mag_big > xy_thresh);
    // Dominant axis and its sign give the plane code.
    assign xy_now    = (mag_x >= mag_y) ? {i_sample.x[11], 1'b0}
                                        : {i_sample.y[11], 1'b1};
    // Readings needed: 16 shifted left by the count code.
    assign target    = 8'(`AEO_ORIENT_BASE << i_orient_count);
    // A flag being cleared this cycle re-arms its axis at once.
    assign armed     = ~st_reg.evt_flags[3:0] | st_reg.evt_ack[3:0];

    // Unfiltered and candidate orientations of the current reading.
    always_comb begin
        inst_now.tilt  = tilt_now;
        inst_now.z_neg = i_sample.z[11];
        inst_now.xy    = tilt_now ? st_reg.inst.xy : xy_now;
        cand           = inst_now;
        cand.xy        = tilt_now ? st_reg.filt.xy : xy_now;
    end

    // ======================================================================
    // Next state
    // ======================================================================

    // All bank behaviour is computed here from the registered state.
    always_comb begin
        st_next = st_reg;

        // Transfer busy passes three flops; a change counts when the last two agree.
        st_next.busy_sync = {st_reg.busy_sync[1:0], i_xfer_busy};
        if (st_reg.busy_sync[1] == st_reg.busy_sync[2]) begin
            st_next.busy = st_reg.busy_sync[2];
        end

        // Clear registers take the written ones and drop them a cycle later.
        st_next.evt_ack   = 8'h00;
        st_next.fresh_ack = 1'b0;
        if (wr_event) begin
            st_next.evt_ack = i_reg_req.wdata & `AEO_EVENT_MASK;
        end
        if (wr_ready) begin
            st_next.fresh_ack = i_reg_req.wdata[`AEO_BIT_FRESH_ACK];
        end

        // Clear first, then set, so an event in the clearing cycle survives.
        st_next.evt_flags      = st_reg.evt_flags & ~st_reg.evt_ack;
        st_next.evt_flags[3:0] = st_next.evt_flags[3:0]
                               | (i_shake_hit & armed);
        st_next.fresh          = (st_reg.fresh & ~st_reg.fresh_ack)
                               | i_sample.valid;

        // Calibration loaded can only ever rise.
        st_next.calib = st_reg.calib | i_calib_done;

        // Each reading updates the outputs and the orientation filter.
        if (i_sample.valid) begin
            st_next.x    = i_sample.x;
            st_next.y    = i_sample.y;
            st_next.inst = inst_now;
            if (cand == st_reg.filt) begin
                // Reading agrees with the committed value: restart counting.
                st_next.cnt = 8'h00;
            end else if ((st_reg.cnt != 8'h00) && (cand == st_reg.pend)) begin
                if (8'(st_reg.cnt + 8'h01) == target) begin
                    // Enough identical readings: commit and flag what moved.
                    st_next.filt = cand;
                    st_next.cnt  = 8'h00;
                    if (cand.xy != st_reg.filt.xy) begin
                        st_next.evt_flags[`AEO_BIT_XY_CHG] = 1'b1;
                    end
                    if ({cand.tilt, cand.z_neg} !=
                        {st_reg.filt.tilt, st_reg.filt.z_neg}) begin
                        st_next.evt_flags[`AEO_BIT_Z_CHG] = 1'b1;
                    end
                end else begin
                    st_next.cnt = 8'(st_reg.cnt + 8'h01);
                end
            end else begin
                // A different new orientation starts a fresh run of one.
                st_next.pend = cand;
                st_next.cnt  = 8'h01;
            end
        end

        // Soft restart sequencer.
        case (st_reg.rst_st)
            aeo_pkg::AEO_RUN: begin
                if (wr_ready && i_reg_req.wdata[`AEO_BIT_SOFT_RST]) begin
                    st_next.rst_st = aeo_pkg::AEO_HOLD;
                end
            end
            aeo_pkg::AEO_HOLD: begin
                // Stay while the requesting transfer is still running.
                if (!st_reg.busy) begin
                    st_next.rst_st = aeo_pkg::AEO_RELEASE;
                end
            end
            aeo_pkg::AEO_RELEASE: begin
                st_next.rst_st = aeo_pkg::AEO_RUN;
            end
            default: begin
                st_next.rst_st = aeo_pkg::AEO_RUN;
            end
        endcase

        // While restarting, bank contents return to power-up values.
        // The register port, busy tracking and calibration flag are kept.
        if (st_next.rst_st != aeo_pkg::AEO_RUN) begin
            st_next.evt_flags = `AEO_RST_BYTE;
            st_next.evt_ack   = `AEO_RST_BYTE;
            st_next.fresh     = 1'b0;
            st_next.fresh_ack = 1'b0;
            st_next.filt      = `AEO_RST_ORIENT;
            st_next.inst      = `AEO_RST_ORIENT;
            st_next.pend      = `AEO_RST_ORIENT;
            st_next.cnt       = 8'h00;
            st_next.x         = 12'h000;
            st_next.y         = 12'h000;
        end

        // Read data is captured on the read strobe.
        if (i_reg_req.rd) begin
            case (i_reg_req.addr)
                `AEO_OFF_EVENT: begin
                    st_next.rdata = st_reg.evt_flags;
                end
                `AEO_OFF_READY: begin
                    st_next.rdata = {st_reg.filt.tilt, st_reg.filt.z_neg,
                                     st_reg.filt.xy, 3'h0, st_reg.fresh};
                end
                `AEO_OFF_INSTANT: begin
                    st_next.rdata = {3'h0, st_reg.calib, st_reg.inst.tilt,
                                     st_reg.inst.z_neg, st_reg.inst.xy};
                end
                `AEO_OFF_XHI: begin
                    st_next.rdata = st_reg.x[11:4];
                end
                `AEO_OFF_XLO: begin
                    st_next.rdata = {st_reg.x[3:0], 4'h0};
                end
                `AEO_OFF_YHI: begin
                    st_next.rdata = st_reg.y[11:4];
                end
                default: begin
                    // Remaining offsets of the sixteen belong to other logic.
                    st_next.rdata = i_other_rdata;
                end
            endcase
        end

        // Interrupt request from enabled flags of the next state.
        st_next.int_act = (|(st_next.evt_flags & i_event_enable))
                        | (|({2'b00, st_next.fresh} & i_ready_enable));
    end

    // ======================================================================
    // State register
    // ======================================================================

    // Single register for the whole state; reset loads constants only.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg           <= '0;
            st_reg.rst_st    <= aeo_pkg::AEO_RUN;
            st_reg.filt      <= `AEO_RST_ORIENT;
            st_reg.evt_flags <= `AEO_RST_BYTE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign o_reg_rdata    = st_reg.rdata;
    assign o_shake_armed  = armed;
    assign o_soft_restart = (st_reg.rst_st != aeo_pkg::AEO_RUN);
    assign o_int_n_o      = 1'b0;
    assign o_int_n_oe     = st_reg.int_act;

    // ======================================================================
    // Assertions and covers
    // ======================================================================
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    // A shake hit on an armed axis sets its flag on the next edge.
    a_shake_flag_set: assert property (
        (i_shake_hit[0] && armed[0] && !wr_ready && !o_soft_restart)
        |=> st_reg.evt_flags[0])
        else $error("shake flag not set after hit");

    // A written one clears the flag two edges later unless a hit returns.
    a_ack_clears: assert property (
        (wr_event && i_reg_req.wdata[0] && !wr_ready && !o_soft_restart)
        ##1 (!i_shake_hit[0] && !wr_ready) |=> !st_reg.evt_flags[0])
        else $error("flag not cleared by clear bit");

    // The clear register empties itself one cycle after a write.
    a_ack_self_clear: assert property (
        (st_reg.evt_ack != 8'h00) && !wr_event |=> (st_reg.evt_ack == 8'h00))
        else $error("clear register did not self-clear");

    // A written zero keeps a set flag for the following two edges.
    a_zero_keeps: assert property (
        (wr_event && !i_reg_req.wdata[0] && st_reg.evt_flags[0]
         && (st_reg.evt_ack == 8'h00) && !o_soft_restart)
        ##1 !wr_event && !wr_ready |=> st_reg.evt_flags[0])
        else $error("flag lost on zero write");

    // A completed reading raises the ready bit.
    a_fresh_set: assert property (
        (i_sample.valid && !wr_ready && !o_soft_restart) |=> st_reg.fresh)
        else $error("ready bit not set by sample");

    // A soft restart write asserts restart on the next edge.
    a_soft_start: assert property (
        (wr_ready && i_reg_req.wdata[4] && !o_soft_restart) |=> o_soft_restart)
        else $error("soft restart not started");

    // Restart stays up while the transfer is seen busy.
    a_soft_hold: assert property (
        (st_reg.rst_st == aeo_pkg::AEO_HOLD) && st_reg.busy
        |=> (st_reg.rst_st == aeo_pkg::AEO_HOLD) [*1])
        else $error("soft restart released during busy transfer");

    // Calibration loaded never falls.
    a_calib_sticky: assert property (
        st_reg.calib |=> st_reg.calib)
        else $error("calibration flag cleared");

    // Lower X register carries the low nibble of the sample, zeros below.
    a_xlo_layout: assert property (
        (i_reg_req.rd && (i_reg_req.addr == `AEO_OFF_XLO))
        |=> (o_reg_rdata == {$past(st_reg.x[3:0]), 4'h0}))
        else $error("lower X register layout wrong");

    // Filtered orientation moves only on the edge after a reading.
    a_filter_moves: assert property (
        !i_sample.valid && !o_soft_restart && (st_reg.rst_st == aeo_pkg::AEO_RUN)
        && !(wr_ready && i_reg_req.wdata[4]) |=> $stable(st_reg.filt))
        else $error("filtered orientation changed without reading");

    // A set shake flag that is not being cleared stays set.
    a_flag_holds: assert property (
        (st_reg.evt_flags[0] && !st_reg.evt_ack[0] && !(wr_ready && i_reg_req.wdata[4]))
        |=> st_reg.evt_flags[0])
        else $error("shake flag lost without clear");

    // A written ready clear drops the ready bit unless a reading returns.
    a_fresh_clear: assert property (
        (wr_ready && i_reg_req.wdata[0]) ##1 !i_sample.valid |=> !st_reg.fresh)
        else $error("ready bit not cleared");

    // Upper X register carries bits eleven to four of the sample.
    a_xhi_layout: assert property (
        (i_reg_req.rd && (i_reg_req.addr == `AEO_OFF_XHI))
        |=> (o_reg_rdata == $past(st_reg.x[11:4])))
        else $error("upper X register layout wrong");

    // Unused bits of the flag register read zero.
    a_unused_zeros: assert property (
        (i_reg_req.rd && (i_reg_req.addr == `AEO_OFF_EVENT))
        |=> (o_reg_rdata[5:4] == 2'b00))
        else $error("unused flag bits not zero");

    // Reserved bits of the instantaneous status register read zero.
    a_status_zeros: assert property (
        (i_reg_req.rd && (i_reg_req.addr == `AEO_OFF_INSTANT))
        |=> (o_reg_rdata[7:5] == 3'b000))
        else $error("status reserved bits not zero");

    // A tilted reading leaves the instantaneous plane code as it was.
    a_tilt_holds_xy: assert property (
        (i_sample.valid && tilt_now && !o_soft_restart && !(wr_ready && i_reg_req.wdata[4]))
        |=> (st_reg.inst.xy == $past(st_reg.inst.xy)))
        else $error("plane code moved while tilted");

    // The interrupt pin is pulled only while some flag is set.
    a_int_has_cause: assert property (
        o_int_n_oe |-> ((st_reg.evt_flags != 8'h00) || st_reg.fresh))
        else $error("interrupt without a set flag");

    // Soft restart holds flags and ready bit at their power-up values.
    a_restart_clears: assert property (
        o_soft_restart |-> ((st_reg.evt_flags == 8'h00) && !st_reg.fresh))
        else $error("flags not cleared during soft restart");

    // The plane change flag rises only with a committed plane code.
    a_xy_commit: assert property (
        $rose(st_reg.evt_flags[`AEO_BIT_XY_CHG]) |-> $changed(st_reg.filt.xy))
        else $error("plane change flag without new plane code");

    c_shake_seen:   cover property (i_shake_hit[0] ##1 st_reg.evt_flags[0]);
    c_soft_restart: cover property ($rose(o_soft_restart) ##[1:100] $fell(o_soft_restart));
    c_xy_commit:    cover property ($rose(st_reg.evt_flags[`AEO_BIT_XY_CHG]));
    c_int_active:   cover property ($rose(o_int_n_oe));
    c_tilt_reading: cover property (i_sample.valid && tilt_now);

endmodule

`default_nettype wire

/* verification/aeo_host_link.sv */
// Host side model that holds the transfer busy level for a number of link clock periods.
`timescale 1ns/1ps
`default_nettype none

module aeo_host_link (
    input  wire logic       i_start,
    input  wire logic [3:0] i_len,
    output logic            o_busy
);
    // ======================================================================
    // Link clock, running only while a transfer is in progress.
    // ======================================================================
    logic lclk;

    // A transfer stays busy for the requested number of 64 ns link periods.
    initial begin
        o_busy = 1'b0;
        lclk   = 1'b0;
        forever begin
            @(posedge i_start);
            o_busy = 1'b1;
            repeat (2 * i_len) #32 lclk = ~lclk;
            o_busy = 1'b0;
        end
    end
endmodule

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench of the event and orientation register bank.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ======================================================================
    // Signals, counters and expectation queue
    // ======================================================================
    logic                  i_clk, i_nrst, calib, srst, int_o, int_oe, busy, go, rd_seen;
    aeo_pkg::aeo_reg_req_t req;
    aeo_pkg::aeo_sample_t  smp;
    logic [7:0]            rdata, other, ev_en;
    logic [3:0]            hit, armed;
    logic [1:0]            fsr, ocnt;
    logic [2:0]            rdy_en;
    logic [31:0]           seed = 32'h59;
    logic [7:0]            expq[$];
    int                    error_cnt = 0;
    int                    comparisons = 0;

    aeo_event_orient_bank aeo_event_orient_bank_i (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_reg_req(req), .o_reg_rdata(rdata), .i_other_rdata(other), .i_xfer_busy(busy),
        .i_sample(smp), .i_shake_hit(hit), .i_calib_done(calib), .i_fsr(fsr),
        .i_orient_count(ocnt), .i_event_enable(ev_en), .i_ready_enable(rdy_en),
        .o_shake_armed(armed), .o_soft_restart(srst), .o_int_n_o(int_o), .o_int_n_oe(int_oe));
    aeo_host_link aeo_host_link_i (.i_start(go), .i_len(4'h4), .o_busy(busy));

    // The 200 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // ======================================================================
    // Tasks
    // ======================================================================
    // Xorshift step of the random source.
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] r;
        r   = s ^ (s << 13);
        r   = r ^ (r >> 17);
        nxt = r ^ (r << 5);
    endfunction

    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One register access of a single cycle.
    task access(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1 req = {w, ~w, a, d};
        @(posedge i_clk);
        #1 req = '0;
    endtask

    // A read notes its expected value before the request goes out.
    task rd(input logic [3:0] a, input logic [7:0] exp);
        expq.push_back(exp);
        access(1'b0, a, 8'h00);
    endtask

    // One cycle of shake hits and an optional sensor reading.
    task strobe(input logic [3:0] h, input logic v, input logic [11:0] x, input logic [11:0] y);
        @(posedge i_clk);
        #1 hit = h;
        smp = {v, x, y, 12'h000};
        @(posedge i_clk);
        #1 hit = 4'h0;
        smp = '0;
    endtask

    task tally_and_finish;
        if (expq.size() != 0) error_cnt++;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Read data is compared on the edge after the read was taken.
    always @(posedge i_clk) begin
        if (rd_seen === 1'b1) check(rdata, expq.pop_front());
        rd_seen <= req.rd;
    end

    // Watchdog against a hang.
    initial begin
        #50000;
        error_cnt++;
        tally_and_finish();
    end

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        req    = '0;
        smp    = '0;
        hit    = 4'h0;
        calib  = 1'b0;
        ev_en  = 8'hFF;
        fsr    = 2'h0;
        ocnt   = 2'h0;
        rdy_en = 3'h0;
        go     = 1'b0;
        i_nrst = 1'b0;
        seed   = nxt(seed);
        other  = seed[7:0];
        repeat (10) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        check({4'h0, armed}, 8'h0F);
        rd(4'h0, 8'h00);
        rd(4'h9, other);
        for (int i = 0; i < 4; i++) strobe(4'h1 << i, 1'b0, 12'h000, 12'h000);
        check({7'h0, int_oe}, 8'h01);
        check({4'h0, armed}, 8'h00);
        rd(4'h0, 8'h0F);
        access(1'b1, 4'h0, 8'h30);
        access(1'b1, 4'h0, 8'h00);
        rd(4'h0, 8'h0F);
        access(1'b1, 4'h0, 8'h05);
        rd(4'h0, 8'h0A);
        strobe(4'h1, 1'b0, 12'h000, 12'h000);
        rd(4'h0, 8'h0B);
        calib = 1'b1;
        @(posedge i_clk);
        #1 calib = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            strobe(4'h0, 1'b1, 12'h000, 12'h400);
            if (i == 1) rd(4'h2, 8'h11);
            if (i == 15) rd(4'h1, 8'h01);
        end
        rd(4'h1, 8'h11);
        rd(4'h0, 8'h4B);
        strobe(4'h0, 1'b1, 12'h000, 12'h100);
        rd(4'h2, 8'h19);
        access(1'b1, 4'h1, 8'h01);
        rd(4'h1, 8'h10);
        ev_en = 8'h00;
        repeat (2) @(posedge i_clk);
        #1 check({6'h0, int_o, int_oe}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            seed = nxt(seed);
            strobe(4'h0, 1'b1, seed[11:0], 12'h400);
            rd(4'h3, seed[11:4]);
            rd(4'h4, {seed[3:0], 4'h0});
        end
        go = 1'b1;
        repeat (4) @(posedge i_clk);
        access(1'b1, 4'h1, 8'h10);
        repeat (20) @(posedge i_clk);
        #1 check({7'h0, srst}, 8'h01);
        for (int i = 0; i < 100 && srst !== 1'b0; i++) begin
            @(posedge i_clk);
            #1;
        end
        check({7'h0, srst | busy}, 8'h00);
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h10);
        // Wider range halves the threshold; longer count needs 32 readings.
        fsr    = 2'h1;
        ocnt   = 2'h1;
        rdy_en = 3'h1;
        for (int i = 1; i <= 32; i++) begin
            strobe(4'h0, 1'b1, 12'h000, 12'h100);
            if (i == 31) rd(4'h1, 8'h01);
        end
        rd(4'h1, 8'h11);
        rd(4'h0, 8'h40);
        check({7'h0, int_oe}, 8'h01);
        go = 1'b0;
        repeat (3) @(posedge i_clk);
        tally_and_finish();
    end
endmodule

`default_nettype wire
